//--- core/scb_port.sv
// slow control serial bus port with hub relay and register bus
`timescale 1ns/1ps
`default_nettype none
`include "scb_cfg.svh"

module scb_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] chip_identifier,
  input wire logic differential_control_port_i,
  output logic differential_control_port_o,
  output logic differential_control_port_oe,
  input wire logic ctrl_i,
  output logic ctrl_o,
  output logic ctrl_oe,
  output logic trig_pulse,
  output logic cmd_pulse,
  output logic [15:0] cmd_code,
  output logic wr_valid,
  output scb_pkg::scb_wr_s wr_req,
  output logic rd_valid,
  output logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import scb_pkg::*;

  logic d_s1, d_s2, c_s1, c_s2;
  logic [6:0] id_s1, id_s2;
  scb_role_e role;
  logic rx_b;
  scb_rx_e rx_st;
  logic [2:0] rx_cnt;
  logic [7:0] rx_sh;
  logic char_v;
  logic [7:0] char_b;
  scb_st_e txn_st;
  logic is_rd, hit;
  logic [5:0] gap;
  logic [15:0] addr_q;
  logic [7:0] dlo;
  logic [6:0] win;
  logic reply_go;
  logic [29:0] tx_sh;
  logic reply_bit, reply_oe;
  logic relay_oe;
  logic man_en;
  logic uni_m, grp_m, glb_m;
  logic aw_ok, w_ok;
  logic [3:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;

  // two-stage synchronisers for pins and straps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d_s1 <= 1'b1;
      d_s2 <= 1'b1;
      c_s1 <= 1'b1;
      c_s2 <= 1'b1;
      id_s1 <= 7'h00;
      id_s2 <= 7'h00;
    end else begin
      d_s1 <= differential_control_port_i;
      d_s2 <= d_s1;
      c_s1 <= ctrl_i;
      c_s2 <= c_s1;
      id_s1 <= chip_identifier;
      id_s2 <= id_s1;
    end
  end

  // role from module and position fields
  always_comb begin
    if (id_s2[6:4] == 3'h0) begin
      role = SCB_DIRECT;
    end else if (id_s2[2:0] == 3'h0) begin
      role = SCB_HUB;
    end else begin
      role = SCB_LEAF;
    end
  end

  // leaf listens on the local line, others on the differential line
  assign rx_b = (role == SCB_LEAF) ? c_s2 : d_s2;

  // deserialiser, paused during the read turnaround window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st <= SCB_RX_IDLE;
      rx_cnt <= 3'h0;
      rx_sh <= 8'h00;
      char_v <= 1'b0;
      char_b <= 8'h00;
    end else begin
      char_v <= 1'b0;
      if (win != 7'h00) begin
        rx_st <= SCB_RX_IDLE;
      end else begin
        case (rx_st)
          SCB_RX_IDLE: begin
            if (!rx_b) begin
              rx_st <= SCB_RX_DATA;
              rx_cnt <= 3'h0;
            end
          end
          SCB_RX_DATA: begin
            rx_sh <= {rx_b, rx_sh[7:1]};
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == 3'h7) begin
              rx_st <= SCB_RX_STOP;
            end
          end
          SCB_RX_STOP: begin
            rx_st <= SCB_RX_IDLE;
            char_v <= rx_b;
            char_b <= rx_sh;
          end
          default: rx_st <= SCB_RX_IDLE;
        endcase
      end
    end
  end

  // early trigger flag from the first two opcode bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= win == 7'h00 && rx_st == SCB_RX_DATA &&
        rx_cnt == 3'h1 && txn_st == SCB_ST_OP &&
        {rx_b, rx_sh[7]} == `SCB_TRIG_LSB;
    end
  end

  // identifier match for unicast, group and global targets
  always_comb begin
    uni_m = char_b == {1'b0, id_s2};
    glb_m = char_b == `SCB_ID_GLOBAL;
    grp_m = char_b[7] == 1'b0 && char_b[2:0] == `SCB_GRP_TAIL &&
      char_b[6:4] == id_s2[6:4] && char_b[3] == id_s2[3] &&
      id_s2[6:4] != 3'h0;
  end

  // idle gap watchdog inside multi-character transactions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 6'h00;
    end else if (txn_st == SCB_ST_OP || rx_st != SCB_RX_IDLE ||
                 !rx_b || win != 7'h00) begin
      gap <= 6'h00;
    end else if (gap <= `SCB_GAP_MAX) begin
      gap <= gap + 6'h01;
    end
  end

  // transaction decoder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txn_st <= SCB_ST_OP;
      is_rd <= 1'b0;
      hit <= 1'b0;
      addr_q <= 16'h0000;
      dlo <= 8'h00;
      cmd_pulse <= 1'b0;
      cmd_code <= 16'h0000;
      wr_valid <= 1'b0;
      wr_req <= '0;
      rd_valid <= 1'b0;
      rd_addr <= 16'h0000;
    end else begin
      cmd_pulse <= 1'b0;
      wr_valid <= 1'b0;
      rd_valid <= 1'b0;
      if (gap > `SCB_GAP_MAX) begin
        txn_st <= SCB_ST_OP;
      end else if (char_v) begin
        case (txn_st)
          SCB_ST_OP: begin
            case (char_b)
              `SCB_OP_TRIG0, `SCB_OP_TRIG1, `SCB_OP_TRIG2,
              `SCB_OP_TRIG3, `SCB_OP_GLOBAL_RESET_CMD, `SCB_OP_MRST,
              `SCB_OP_INJ, `SCB_OP_BCLR, `SCB_OP_SNAP,
              `SCB_OP_READOUT_RESET_CMD: begin
                cmd_pulse <= 1'b1;
                cmd_code <= {8'h00, char_b};
              end
              `SCB_OP_WR: begin
                txn_st <= SCB_ST_ID;
                is_rd <= 1'b0;
              end
              `SCB_OP_RD: begin
                txn_st <= SCB_ST_ID;
                is_rd <= 1'b1;
              end
              default: txn_st <= SCB_ST_OP;
            endcase
          end
          SCB_ST_ID: begin
            hit <= uni_m || (!is_rd && (glb_m || grp_m));
            txn_st <= SCB_ST_AL;
          end
          SCB_ST_AL: begin
            addr_q[7:0] <= char_b;
            txn_st <= SCB_ST_AH;
          end
          SCB_ST_AH: begin
            addr_q[15:8] <= char_b;
            txn_st <= is_rd ? SCB_ST_OP : SCB_ST_DL;
            rd_valid <= is_rd && hit;
            rd_addr <= {char_b, addr_q[7:0]};
          end
          SCB_ST_DL: begin
            dlo <= char_b;
            txn_st <= SCB_ST_DH;
          end
          SCB_ST_DH: begin
            txn_st <= SCB_ST_OP;
            wr_valid <= hit;
            wr_req <= {addr_q, char_b, dlo};
            if (hit && addr_q == `SCB_CMD_ADDR) begin
              cmd_pulse <= 1'b1;
              cmd_code <= {char_b, dlo};
            end
          end
          default: txn_st <= SCB_ST_OP;
        endcase
      end
    end
  end

  // read turnaround window counter, all chips pause sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win <= 7'h00;
      reply_go <= 1'b0;
    end else if (char_v && txn_st == SCB_ST_AH && is_rd &&
                 gap <= `SCB_GAP_MAX) begin
      win <= 7'h01;
      reply_go <= hit;
    end else if (win == `SCB_WIN_END) begin
      win <= 7'h00;
      reply_go <= 1'b0;
    end else if (win != 7'h00) begin
      win <= win + 7'h01;
    end
  end

  // reply shifter: id, data low, data high, back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh <= '1;
      reply_bit <= 1'b1;
      reply_oe <= 1'b0;
    end else begin
      reply_oe <= reply_go && win >= `SCB_WIN_DRV &&
        win < `SCB_WIN_REL;
      if (win == `SCB_WIN_LOAD) begin
        tx_sh <= {1'b1, rd_data[15:8], 1'b0, 1'b1, rd_data[7:0],
          1'b0, 1'b1, 1'b0, id_s2, 1'b0};
      end else if (win >= `SCB_WIN_TX && win < `SCB_WIN_TXEND) begin
        tx_sh <= {1'b1, tx_sh[29:1]};
      end
      if (win >= `SCB_WIN_TX && win < `SCB_WIN_TXEND) begin
        reply_bit <= tx_sh[0];
      end else begin
        reply_bit <= 1'b1;
      end
    end
  end

  // hub forwarding and relay of leaf replies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_oe <= 1'b0;
      ctrl_o <= 1'b1;
      ctrl_oe <= 1'b0;
      differential_control_port_o <= 1'b1;
    end else begin
      relay_oe <= role == SCB_HUB && !reply_go &&
        win >= `SCB_WIN_DRV && win < `SCB_WIN_REL;
      if (role == SCB_HUB) begin
        ctrl_oe <= win < `SCB_WIN_DRV || win >= `SCB_WIN_REL;
        ctrl_o <= (win == 7'h00) ? d_s2 : 1'b1;
        differential_control_port_o <= reply_go ? reply_bit : c_s2;
      end else if (role == SCB_LEAF) begin
        ctrl_oe <= reply_oe;
        ctrl_o <= reply_bit;
        differential_control_port_o <= 1'b1;
      end else begin
        ctrl_oe <= 1'b0;
        ctrl_o <= 1'b1;
        differential_control_port_o <= reply_bit;
      end
    end
  end

  // differential driver enable for own reply or relayed reply
  assign differential_control_port_oe = (role != SCB_LEAF) && (reply_oe || relay_oe);

  // register bus: write channel accepts address and data in any order
  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready = !w_ok && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_a <= 4'h0;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      man_en <= 1'(`SCB_CTRL_RST);
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (aw_ok && w_ok) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_a == `SCB_REG_CTRL) begin
          if (w_s[0]) begin
            man_en <= w_d[`SCB_CTRL_MAN];
          end
        end else if (aw_a != `SCB_REG_STAT && aw_a != `SCB_REG_CMD &&
                     aw_a != `SCB_REG_ADDR) begin
          s_axi_bresp <= 2'h3;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register bus: read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `SCB_REG_CTRL: s_axi_rdata <= {31'h0, man_en};
        `SCB_REG_STAT: s_axi_rdata <= {16'h0, 1'b0, txn_st, 1'b0,
          id_s2, role, reply_go, win != 7'h00};
        `SCB_REG_CMD: s_axi_rdata <= {16'h0, cmd_code};
        `SCB_REG_ADDR: s_axi_rdata <= {16'h0, addr_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h3;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // optional biphase coded copy of the hub's differential output or of the other roles' reply bit, not driven to any port
  logic d_line;
  assign d_line = (role == SCB_HUB) ? differential_control_port_o : reply_bit;
  logic differential_control_port_code;
  assign differential_control_port_code = man_en ? (d_line ^ aclk) : d_line;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence char_frame;
    (rx_st == SCB_RX_DATA) [*8] ##1 (rx_st == SCB_RX_STOP);
  endsequence

  rx_frame_a: assert property (
    (rx_st == SCB_RX_IDLE && !rx_b && win == 7'h00) |=> char_frame)
    else $error("character frame is not ten bits");

  trig_early_a: assert property (
    (char_v && txn_st == SCB_ST_OP && char_b == `SCB_OP_TRIG1)
      |-> $past(trig_pulse, 7))
    else $error("trigger not flagged early");

  bcast_cmd_a: assert property (
    (char_v && txn_st == SCB_ST_OP && char_b == `SCB_OP_GLOBAL_RESET_CMD)
      |=> cmd_pulse && cmd_code == 16'h00d2)
    else $error("broadcast command not executed");

  bad_op_a: assert property (
    (char_v && txn_st == SCB_ST_OP && char_b == 8'hd3)
      |=> txn_st == SCB_ST_OP && !cmd_pulse)
    else $error("corrupted opcode executed");

  gap_abort_a: assert property (
    (gap > `SCB_GAP_MAX) |=> txn_st == SCB_ST_OP)
    else $error("stale transaction kept");

  wr_hit_a: assert property (
    wr_valid |-> $past(hit))
    else $error("write stored by unaddressed chip");

  sequence reply_starts;
    !reply_bit ##10 !reply_bit ##10 !reply_bit;
  endsequence

  reply_b2b_a: assert property (
    (reply_go && win == 7'h10) |-> reply_starts)
    else $error("reply characters not back to back");

  reply_idle_a: assert property (
    (reply_oe && win < 7'h10) |-> reply_bit)
    else $error("reply line not idle before start");

  reply_oe_a: assert property (
    $rose(reply_oe) |-> win == 7'h06 && $past(reply_go))
    else $error("reply driver outside window");

  leaf_port_a: assert property (
    (role == SCB_LEAF) |-> !differential_control_port_oe)
    else $error("leaf drives differential port");
endmodule : scb_port
`default_nettype wire

//--- core/scb_cfg.svh
// constants of the slow control serial bus port
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
// opcodes
`define SCB_OP_TRIG0 8'hb1
`define SCB_OP_TRIG1 8'h55
`define SCB_OP_TRIG2 8'hc9
`define SCB_OP_TRIG3 8'h2d
`define SCB_OP_GLOBAL_RESET_CMD 8'hd2
`define SCB_OP_MRST 8'he4
`define SCB_OP_INJ 8'h78
`define SCB_OP_BCLR 8'h36
`define SCB_OP_SNAP 8'haa
`define SCB_OP_READOUT_RESET_CMD 8'h63
`define SCB_OP_WR 8'h9c
`define SCB_OP_RD 8'h4e
// early trigger pattern of the two low opcode bits
`define SCB_TRIG_LSB 2'h1
// identifier codes
`define SCB_ID_GLOBAL 8'h0f
`define SCB_GRP_TAIL 3'h7
// timing in clock cycles
`define SCB_GAP_MAX 6'h2a
`define SCB_WIN_LOAD 7'h04
`define SCB_WIN_DRV 7'h05
`define SCB_WIN_TX 7'h0f
`define SCB_WIN_TXEND 7'h2d
`define SCB_WIN_REL 7'h37
`define SCB_WIN_END 7'h3c
// command register address
`define SCB_CMD_ADDR 16'h0000
// register byte offsets
`define SCB_REG_CTRL 4'h0
`define SCB_REG_STAT 4'h4
`define SCB_REG_CMD 4'h8
`define SCB_REG_ADDR 4'hc
`define SCB_CTRL_RST 32'h0000_0001
`define SCB_CTRL_MAN 0
`endif

//--- core/scb_pkg.sv
// types of the slow control serial bus port
package scb_pkg;
  typedef enum logic [1:0] {
    SCB_DIRECT = 2'h0,
    SCB_HUB = 2'h1,
    SCB_LEAF = 2'h2
  } scb_role_e;
  typedef enum logic [1:0] {
    SCB_RX_IDLE = 2'h0,
    SCB_RX_DATA = 2'h1,
    SCB_RX_STOP = 2'h2
  } scb_rx_e;
  typedef enum logic [2:0] {
    SCB_ST_OP = 3'h0,
    SCB_ST_ID = 3'h1,
    SCB_ST_AL = 3'h2,
    SCB_ST_AH = 3'h3,
    SCB_ST_DL = 3'h4,
    SCB_ST_DH = 3'h5
  } scb_st_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } scb_wr_s;
endpackage : scb_pkg

//--- verification/scb_master_model.sv
// bus master model driving the differential control line
`timescale 1ns/1ps
`default_nettype none
module scb_master_model (
  input wire logic aclk,
  input wire logic sense,
  input wire logic sense_oe,
  output logic line
);
  logic drv_bit = 1'b1;
  logic drv_en = 1'b1;
  logic tgl = 1'b0;
  logic [29:0] rx = '0;
  int nb = 0;
  int cyc = 0;
  int st = 0;
  int clash = 0;
  // a released line shows a changing pattern, not its last value
  assign line = sense_oe ? sense : (drv_en ? drv_bit : tgl);
  // toggle pattern and contention watch
  always @(posedge aclk) begin
    tgl <= ~tgl;
    if (sense_oe && drv_en) clash <= clash + 1;
  end
  // reply capture while released, mid-cycle sampling
  always @(negedge aclk) begin
    if (!drv_en && nb > 0 && nb < 30) begin
      rx[nb] <= sense;
      nb <= nb + 1;
    end else if (!drv_en && nb == 0 && sense_oe && !sense) begin
      rx[0] <= 1'b0;
      nb <= 1;
      st <= cyc;
    end
  end
  // one framed character, lsb first, then idle gap
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      drv_bit <= f[i];
    end
    repeat (gap) begin
      @(posedge aclk);
      drv_bit <= 1'b1;
    end
  endtask : send
  // read request, then release for the reply window
  task automatic read(input logic [7:0] id, input logic [15:0] a);
    nb = 0;
    send(8'h4e, 0);
    send(id, 0);
    send(a[7:0], 0);
    send(a[15:8], 0);
    for (int c = 0; c < 63; c++) begin
      @(posedge aclk);
      cyc = c;
      if (c == 5) drv_en <= 1'b0;
      if (c == 60) drv_en <= 1'b1;
    end
  endtask : read
endmodule : scb_master_model
`default_nettype wire

//--- verification/scb_port_tb_top.sv
// testbench of the slow control serial bus port
`timescale 1ns/1ps
`default_nettype none
module slow_control_bus_transactions_tb_top;
  import scb_pkg::*;
  localparam logic [6:0] ID = 7'h03;
  localparam logic [15:0] RDV = 16'hbeef;
  logic aclk = 0;
  logic aresetn = 0;
  logic [6:0] chip_identifier = ID;
  logic differential_control_port_i, differential_control_port_o, differential_control_port_oe, ctrl_o, ctrl_oe;
  logic ctrl_i = 1'b1;
  logic trig_pulse, cmd_pulse, wr_valid, rd_valid;
  logic [15:0] cmd_code, rd_addr;
  logic [15:0] rd_data = RDV;
  scb_wr_s wr_req, last_wr;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0, check_count = 0;
  int n_trig = 0, n_cmd = 0, n_wr = 0, n_rd = 0, n_loc = 0, n_rel = 0;
  logic [7:0] trg [4] = '{8'hb1, 8'h55, 8'hc9, 8'h2d};
  logic [7:0] bc [6] = '{8'hd2, 8'he4, 8'h78, 8'h36, 8'haa, 8'h63};

  scb_port scb_port_i (.aclk, .aresetn, .chip_identifier, .differential_control_port_i,
    .differential_control_port_o, .differential_control_port_oe, .ctrl_i, .ctrl_o, .ctrl_oe, .trig_pulse,
    .cmd_pulse, .cmd_code, .wr_valid, .wr_req, .rd_valid, .rd_addr,
    .rd_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  scb_master_model scb_master_model_i (.aclk(aclk), .sense(differential_control_port_o),
    .sense_oe(differential_control_port_oe), .line(differential_control_port_i));

  // clock, 5 ns period
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // pulse counters
  always @(posedge aclk) begin
    if (trig_pulse === 1'b1) n_trig <= n_trig + 1;
    if (cmd_pulse === 1'b1) n_cmd <= n_cmd + 1;
    if (rd_valid === 1'b1) n_rd <= n_rd + 1;
    if (aresetn && ctrl_oe !== 1'b0) n_loc <= n_loc + 1;
    if (ctrl_oe === 1'b1 && ctrl_o === 1'b0) n_rel <= n_rel + 1;
    if (wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= wr_req;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // register bus write, both channels offered together
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask : axw
  // register bus read
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    s_axi_rready <= 0;
  endtask : axr
  task automatic tx(input logic [7:0] b, input int g);
    scb_master_model_i.send(b, g);
  endtask : tx
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // six-character write with a fixed gap
  task automatic wr6(input logic [7:0] id, input logic [15:0] a,
                     input logic [15:0] d, input int g);
    tx(8'h9c, g);
    tx(id, g);
    tx(a[7:0], g);
    tx(a[15:8], g);
    tx(d[7:0], g);
    tx(d[15:8], g);
    wt(12);
  endtask : wr6
  // watchdog, far beyond the expected run length
  initial begin
    wt(20000);
    num_errors++;
    $display("watchdog expired");
    results();
  end
  // main sequence
  initial begin
    wt(6);
    aresetn <= 1;
    wt(5);
    chk("differential_control_port_oe", 0, 32'(differential_control_port_oe));
    axr(4'h0, rd);
    chk("ctrl reset", 32'h1, rd);
    axr(4'h4, rd);
    chk("role", 0, 32'(rd[3:2]));
    chk("id field", 32'(ID), 32'(rd[10:4]));
    axw(4'h0, 32'h0);
    axr(4'h0, rd);
    chk("ctrl off", 32'h0, rd);
    axw(4'h0, 32'h1);
    $display("test registers done");
    foreach (trg[i]) begin
      tx(trg[i], 3);
      wt(12);
      chk("trig count", 32'(i + 1), 32'(n_trig));
      chk("trig cmd", 32'(trg[i]), 32'(cmd_code));
    end
    foreach (bc[i]) begin
      tx(bc[i], 0);
      wt(12);
      chk("bcast cmd", 32'(bc[i]), 32'(cmd_code));
    end
    chk("cmd count", 10, 32'(n_cmd));
    chk("trig only", 4, 32'(n_trig));
    tx(8'hb0, 0);
    tx(8'hd3, 0);
    wt(12);
    chk("bad op", 10, 32'(n_cmd));
    $display("test commands done");
    wr6({1'b0, ID}, 16'h0123, 16'h4567, 42);
    chk("wr count", 1, 32'(n_wr));
    chk("wr req", 32'h0123_4567, last_wr);
    wr6(8'h05, 16'h0001, 16'h1111, 0);
    chk("wr other", 1, 32'(n_wr));
    wr6(8'h0f, 16'h0000, 16'h00d2, 0);
    chk("wr global", 2, 32'(n_wr));
    chk("wr cmd", 32'h00d2, 32'(cmd_code));
    tx(8'h9c, 0);
    tx({1'b0, ID}, 43);
    tx(8'h11, 0);
    tx(8'h22, 0);
    tx(8'h33, 0);
    tx(8'h44, 0);
    wt(12);
    chk("wr abandon", 2, 32'(n_wr));
    $display("test writes done");
    scb_master_model_i.read({1'b0, ID}, 16'h0abc);
    chk("rd count", 1, 32'(n_rd));
    chk("rd addr", 32'h0abc, 32'(rd_addr));
    chk("reply len", 30, 32'(scb_master_model_i.nb));
    chk("reply bits", 32'({1'b1, RDV[15:8], 2'b01, RDV[7:0], 3'b010, ID,
      1'b0}), 32'(scb_master_model_i.rx));
    chk("reply start", 1, 32'(scb_master_model_i.st >= 15 &&
      scb_master_model_i.st <= 20));
    scb_master_model_i.read(8'h05, 16'h0abc);
    chk("rd other", 1, 32'(n_rd));
    chk("no reply", 0, 32'(scb_master_model_i.nb));
    chk("clash", 0, 32'(scb_master_model_i.clash));
    chk("local oe", 0, 32'(n_loc));
    $display("test reads done");
    // hub role: module 2, hub bit 1, position 0
    chip_identifier <= 7'h28;
    wt(4);
    axr(4'h4, rd);
    chk("hub role", 1, 32'(rd[3:2]));
    chk("hub local oe", 1, 32'(ctrl_oe));
    wr6(8'h2f, 16'h0002, 16'h5a5a, 0);
    chk("wr group", 3, 32'(n_wr));
    chk("wr group data", 32'h0002_5a5a, last_wr);
    chk("relay zeros", 36, 32'(n_rel));
    wr6(8'h27, 16'h0002, 16'h5a5a, 0);
    chk("wr other group", 3, 32'(n_wr));
    // leaf role: module 2, hub bit 1, position 1
    chip_identifier <= 7'h29;
    wt(4);
    axr(4'h4, rd);
    chk("leaf role", 2, 32'(rd[3:2]));
    chk("leaf diff oe", 0, 32'(differential_control_port_oe));
    $display("test roles done");
    results();
  end
endmodule : slow_control_bus_transactions_tb_top
`default_nettype wire
